// >>> eei_pin_model.sv
// io port pins feeding the edge interrupt block
`timescale 1ns/1ps
module eei_pin_model
  import eei_pkg::*;
(
  input  wire logic [EEI_PIN_W-1:0] drive_level,
  output logic      [EEI_L0_W-1:0]  line0_sub_input,
  output logic      [EEI_PA_W-1:0]  port_a_pin,
  output logic      [EEI_PB_W-1:0]  port_b_pin,
  output logic      [EEI_PC_W-1:0]  port_c_pin
);
  // push-pull pins, always driven, so no released state
  assign line0_sub_input = drive_level[15:0];
  assign port_a_pin      = drive_level[31:16];
  assign port_b_pin      = drive_level[47:32];
  assign port_c_pin      = drive_level[59:48];
endmodule // eei_pin_model

// >>> eei_pkg.sv
// constants for the external edge interrupt block
package eei_pkg;
  localparam int          EEI_NIN     = 19;
  localparam int          EEI_AW      = 5;
  localparam int          EEI_DW      = 32;
  localparam int          EEI_PA_W    = 16;
  localparam int          EEI_PB_W    = 16;
  localparam int          EEI_PC_W    = 12;
  localparam int          EEI_L0_W    = 16;
  localparam int          EEI_PIN_W   = 60;
  localparam int          EEI_L1_BIT  = 16;
  localparam int          EEI_L2_BIT  = 17;
  localparam int          EEI_L3_BIT  = 18;
  localparam int          EEI_L0_MSB  = 15;
  localparam int          EEI_S1_LSB  = 0;
  localparam int          EEI_S2_LSB  = 4;
  localparam int          EEI_S3_LSB  = 8;
  localparam int          EEI_SEL_W   = 4;
  localparam int          EEI_RDY_N   = 3;
  localparam logic [4:0]  EEI_OFS_EN   = 5'h00;
  localparam logic [4:0]  EEI_OFS_RISE = 5'h04;
  localparam logic [4:0]  EEI_OFS_FALL = 5'h08;
  localparam logic [4:0]  EEI_OFS_FLAG = 5'h0C;
  localparam logic [4:0]  EEI_OFS_SEL  = 5'h10;
  localparam logic [31:0] EEI_EN_RST   = 32'h00000000;
  localparam logic [31:0] EEI_RISE_RST = 32'h00000000;
  localparam logic [31:0] EEI_FALL_RST = 32'h0007FFFF;
  localparam logic [31:0] EEI_FLAG_RST = 32'h00000000;
  localparam logic [31:0] EEI_SEL_RST  = 32'h00000000;
  localparam logic [31:0] EEI_IN_MASK  = 32'h0007FFFF;
  localparam logic [31:0] EEI_SEL_MASK = 32'h00000FFF;
  localparam logic [3:0]  EEI_L3_MAX   = 4'hB;
  localparam logic [3:0]  EEI_L2_RSV   = 4'h0;
endpackage

// >>> eei_top.sv
// external edge interrupt controller with avalon-mm register slave
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/1ps

module eei_top
  import eei_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire logic [EEI_AW-1:0]     avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [EEI_DW-1:0]     avs_writedata,
  input  wire logic [3:0]            avs_byteenable,
  output logic      [EEI_DW-1:0]     avs_readdata,
  output logic                       avs_waitrequest,
  input  wire logic [EEI_L0_W-1:0]   line0_sub_input,
  input  wire logic [EEI_PA_W-1:0]   port_a_pin,
  input  wire logic [EEI_PB_W-1:0]   port_b_pin,
  input  wire logic [EEI_PC_W-1:0]   port_c_pin,
  input  wire logic                  standby,
  output logic      [3:0]            line_irq,
  output logic                       irq,
  output logic                       wake_req
);

  logic [EEI_DW-1:0]    line_interrupt_enable;
  logic [EEI_DW-1:0]    rising_edge_enable;
  logic [EEI_DW-1:0]    falling_edge_enable;
  logic [EEI_DW-1:0]    trigger_request_flags;
  logic [EEI_DW-1:0]    line_source_select;
  logic [EEI_PIN_W-1:0] pin_meta;
  logic [EEI_PIN_W-1:0] pin_sync;
  logic [EEI_NIN-1:0]   line_in;
  logic [EEI_NIN-1:0]   line_prev;
  logic [EEI_NIN-1:0]   line_valid;
  logic [EEI_NIN-1:0]   trig;
  logic [EEI_NIN-1:0]   rise_evt;
  logic [EEI_NIN-1:0]   fall_evt;
  logic [EEI_NIN-1:0]   level_hit;
  logic [EEI_NIN-1:0]   clr_hit;
  logic [EEI_RDY_N-1:0] primed;
  logic [EEI_NIN-1:0]   flag_bits;
  logic [EEI_DW-1:0]    be_mask;
  logic [3:0]           line1_source_field;
  logic [3:0]           line2_source_field;
  logic [3:0]           line3_source_field;
  logic                 wr_go;
  logic                 rd_take;

  // byte lanes to bit mask
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // byte-lane merge limited to implemented bits
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  be,
                                        input logic [31:0] keep);
    logic [31:0] m;
    m     = lane_mask(be);
    merge = ((old & ~m) | (wd & m)) & keep;
  endfunction

  // address match for an accepted write
  function automatic logic hit(input logic [4:0] a, input logic [4:0] ofs);
    hit = (a == ofs);
  endfunction

  assign wr_go   = avs_write & ~avs_waitrequest;
  assign rd_take = avs_read & avs_waitrequest;
  assign be_mask = lane_mask(avs_byteenable);

  // bus handshake: one wait cycle per access
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      avs_waitrequest <= 1'b1;
    end else if ((avs_read | avs_write) & avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // read data captured in the wait cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      avs_readdata <= '0;
    end else if (rd_take) begin
      case (avs_address)
        EEI_OFS_EN:   avs_readdata <= line_interrupt_enable;
        EEI_OFS_RISE: avs_readdata <= rising_edge_enable;
        EEI_OFS_FALL: avs_readdata <= falling_edge_enable;
        EEI_OFS_FLAG: avs_readdata <= trigger_request_flags;
        EEI_OFS_SEL:  avs_readdata <= line_source_select;
        default:      avs_readdata <= '0;
      endcase
    end
  end

  // line enable register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      line_interrupt_enable <= EEI_EN_RST;
    end else if (wr_go && hit(avs_address, EEI_OFS_EN)) begin
      line_interrupt_enable <= merge(line_interrupt_enable, avs_writedata,
                                     avs_byteenable, EEI_IN_MASK);
    end
  end

  // rising edge enable register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rising_edge_enable <= EEI_RISE_RST;
    end else if (wr_go && hit(avs_address, EEI_OFS_RISE)) begin
      rising_edge_enable <= merge(rising_edge_enable, avs_writedata,
                                  avs_byteenable, EEI_IN_MASK);
    end
  end

  // falling edge enable register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      falling_edge_enable <= EEI_FALL_RST;
    end else if (wr_go && hit(avs_address, EEI_OFS_FALL)) begin
      falling_edge_enable <= merge(falling_edge_enable, avs_writedata,
                                   avs_byteenable, EEI_IN_MASK);
    end
  end

  // source select register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      line_source_select <= EEI_SEL_RST;
    end else if (wr_go && hit(avs_address, EEI_OFS_SEL)) begin
      line_source_select <= merge(line_source_select, avs_writedata,
                                  avs_byteenable, EEI_SEL_MASK);
    end
  end

  assign line1_source_field = line_source_select[EEI_S1_LSB +: EEI_SEL_W];
  assign line2_source_field = line_source_select[EEI_S2_LSB +: EEI_SEL_W];
  assign line3_source_field = line_source_select[EEI_S3_LSB +: EEI_SEL_W];

  // two-stage pin synchroniser
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= {port_c_pin, port_b_pin, port_a_pin, line0_sub_input};
      pin_sync <= pin_meta;
    end
  end

  // detection held off until the synchroniser has filled
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      primed <= '0;
    end else begin
      primed <= {primed[EEI_RDY_N-2:0], 1'b1};
    end
  end

  // source routing: line 0 takes all sub-inputs, lines 1..3 one pin each
  always_comb begin
    line_in    = '0;
    line_valid = '1;
    line_in[EEI_L0_MSB:0] = pin_sync[EEI_L0_W-1:0];
    line_in[EEI_L1_BIT] = pin_sync[EEI_L0_W + 32'(line1_source_field)];
    line_in[EEI_L2_BIT] =
      pin_sync[EEI_L0_W + EEI_PA_W + 32'(line2_source_field)];
    line_valid[EEI_L2_BIT] = (line2_source_field != EEI_L2_RSV);
    line_valid[EEI_L3_BIT] = (line3_source_field <= EEI_L3_MAX);
    if (line_valid[EEI_L3_BIT]) begin
      line_in[EEI_L3_BIT] =
        pin_sync[EEI_L0_W + EEI_PA_W + EEI_PB_W + 32'(line3_source_field)];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      line_prev <= '0;
    end else begin
      line_prev <= line_in;
    end
  end

  // edge qualification against the selected edge types
  always_comb begin
    rise_evt = line_in & ~line_prev & line_valid & {EEI_NIN{primed[EEI_RDY_N-1]}};
    fall_evt = ~line_in & line_prev & line_valid & {EEI_NIN{primed[EEI_RDY_N-1]}};
    trig = (rise_evt & rising_edge_enable[EEI_NIN-1:0])
         | (fall_evt & falling_edge_enable[EEI_NIN-1:0]);
    clr_hit = (wr_go && hit(avs_address, EEI_OFS_FLAG))
            ? (avs_writedata[EEI_NIN-1:0] & be_mask[EEI_NIN-1:0])
            : '0;
  end

  // sticky request flags, a new event wins over a clear
  genvar gi;
  generate
    for (gi = 0; gi < EEI_NIN; gi++) begin : g_flag
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          flag_bits[gi] <= EEI_FLAG_RST[gi];
        end else if (trig[gi]) begin
          flag_bits[gi] <= 1'b1;
        end else if (clr_hit[gi]) begin
          flag_bits[gi] <= 1'b0;
        end
      end
    end
  endgenerate
  assign trigger_request_flags = {{(EEI_DW-EEI_NIN){1'b0}}, flag_bits};

  // per-line and combined interrupt requests
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      line_irq <= '0;
      irq      <= 1'b0;
    end else begin
      line_irq[0] <= |(trigger_request_flags[EEI_L0_MSB:0]
                     & line_interrupt_enable[EEI_L0_MSB:0]);
      line_irq[1] <= trigger_request_flags[EEI_L1_BIT]
                     & line_interrupt_enable[EEI_L1_BIT];
      line_irq[2] <= trigger_request_flags[EEI_L2_BIT]
                     & line_interrupt_enable[EEI_L2_BIT];
      line_irq[3] <= trigger_request_flags[EEI_L3_BIT]
                     & line_interrupt_enable[EEI_L3_BIT];
      irq <= |(trigger_request_flags[EEI_NIN-1:0]
             & line_interrupt_enable[EEI_NIN-1:0]);
    end
  end

  // standby wake on level
  always_comb begin
    level_hit = (rising_edge_enable[EEI_NIN-1:0] & ~falling_edge_enable[EEI_NIN-1:0]
                 & line_in)
              | (falling_edge_enable[EEI_NIN-1:0] & ~line_in);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wake_req <= 1'b0;
    end else begin
      wake_req <= standby & |(level_hit & line_valid
                  & line_interrupt_enable[EEI_NIN-1:0]);
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  rise_flag_a: assert property (
    (rise_evt[EEI_L1_BIT] && rising_edge_enable[EEI_L1_BIT])
    |=> trigger_request_flags[EEI_L1_BIT])
    else $error("rising edge did not set line 1 flag");

  fall_flag_a: assert property (
    (fall_evt[0] && falling_edge_enable[0]) |=> trigger_request_flags[0])
    else $error("falling edge did not set sub-input 0 flag");

  no_edge_a: assert property (
    (!trigger_request_flags[EEI_L2_BIT] && !trig[EEI_L2_BIT])
    |=> !trigger_request_flags[EEI_L2_BIT])
    else $error("line 2 flag set without an edge");

  w1c_clear_a: assert property (
    (clr_hit[EEI_L3_BIT] && !trig[EEI_L3_BIT]) |=> !trigger_request_flags[EEI_L3_BIT])
    else $error("write one did not clear line 3 flag");

  w0_keep_a: assert property (
    (trigger_request_flags[5] && !clr_hit[5]) |=> trigger_request_flags[5])
    else $error("flag dropped without a write one");

  fall_reset_a: assert property (
    $rose(primed[0]) |-> (falling_edge_enable == EEI_FALL_RST))
    else $error("falling enables not all set after reset");

  line1_irq_a: assert property (
    ##1 line_irq[1] == $past(trigger_request_flags[EEI_L1_BIT]
                       && line_interrupt_enable[EEI_L1_BIT]))
    else $error("line 1 request does not follow flag and enable");

  line3_irq_a: assert property (
    (!line_interrupt_enable[EEI_L3_BIT] && !$past(line_interrupt_enable[EEI_L3_BIT]))
    |-> !line_irq[3])
    else $error("line 3 request while disabled");

  line0_irq_a: assert property (
    (trigger_request_flags[7] && line_interrupt_enable[7]) |=> line_irq[0] && irq)
    else $error("sub-input 7 request missing");

  l3_invalid_a: assert property (
    (line3_source_field > EEI_L3_MAX) |-> !trig[EEI_L3_BIT])
    else $error("line 3 triggered from an invalid source");

  l2_reserved_a: assert property (
    (line2_source_field == EEI_L2_RSV) |-> !trig[EEI_L2_BIT])
    else $error("line 2 triggered from reserved code");

  double_edge_a: assert property (
    (rising_edge_enable[1] && falling_edge_enable[1] && (rise_evt[1] || fall_evt[1]))
    |=> trigger_request_flags[1])
    else $error("double edge missed on sub-input 1");

  wake_high_a: assert property (
    (standby && line_interrupt_enable[0] && rising_edge_enable[0]
     && !falling_edge_enable[0] && line_in[0]) |=> wake_req)
    else $error("high level did not wake");

  wake_low_a: assert property (
    (standby && line_interrupt_enable[2] && falling_edge_enable[2] && !line_in[2])
    |=> wake_req)
    else $error("low level did not wake");

  wake_idle_a: assert property (
    !standby |=> !wake_req)
    else $error("wake outside standby");

  sync_delay_a: assert property (
    primed[EEI_RDY_N-1] && $changed(line0_sub_input[3]) ##1 $stable(line0_sub_input[3])[*3]
    |-> line_in[3] == line0_sub_input[3])
    else $error("sub-input 3 not through two stages");

  bus_wait_a: assert property (
    (avs_read && avs_waitrequest) |=> !avs_waitrequest)
    else $error("read not answered after one wait cycle");

  flag_hold_a: assert property (
    (trigger_request_flags[EEI_L1_BIT] && !clr_hit[EEI_L1_BIT])
    |=> trigger_request_flags[EEI_L1_BIT])
    else $error("line 1 flag dropped without a clear");

  rise_off_a: assert property (
    (rise_evt[3] && !rising_edge_enable[3] && !trigger_request_flags[3])
    |=> !trigger_request_flags[3])
    else $error("disabled rising edge set sub-input 3 flag");

  line2_irq_a: assert property (
    (trigger_request_flags[EEI_L2_BIT] && line_interrupt_enable[EEI_L2_BIT])
    |=> line_irq[2] && irq)
    else $error("line 2 request missing");

  irq_follow_a: assert property (
    ##1 irq == $past(|(trigger_request_flags[EEI_NIN-1:0]
                       & line_interrupt_enable[EEI_NIN-1:0])))
    else $error("combined request does not follow flags and enables");

  wr_wait_a: assert property (
    (avs_write && avs_waitrequest) |=> !avs_waitrequest)
    else $error("write not answered after one wait cycle");

endmodule // eei_top

// >>> eei_top_tb_top.sv
// self-checking bench for the external edge interrupt block
`timescale 1ns/1ps
module eei_top_tb_top;
  import eei_pkg::*;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [4:0]  adr = '0;
  logic        rd_s = 1'b0;
  logic        wr_s = 1'b0;
  logic        stby = 1'b0;
  logic [3:0]  be = 4'hF;
  logic [31:0] wdat = '0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic        wait_s;
  logic        irq;
  logic        wake;
  logic [3:0]  lirq;
  logic [15:0] l0 = 16'hFFFF;
  logic [15:0] la = '0;
  logic [15:0] lb = '0;
  logic [11:0] lc = '0;
  logic [15:0] p0;
  logic [15:0] pa;
  logic [15:0] pb;
  logic [11:0] pc;
  int          bad_count = 0;
  int          num_checks = 0;

  always #25 clk = ~clk;

  eei_pin_model eei_pin_model_i (.drive_level({lc, lb, la, l0}), .line0_sub_input(p0),
    .port_a_pin(pa), .port_b_pin(pb), .port_c_pin(pc));

  eei_top eei_top_i (.clk(clk), .reset_n(reset_n), .avs_address(adr), .avs_read(rd_s),
    .avs_write(wr_s), .avs_writedata(wdat), .avs_byteenable(be), .avs_readdata(rdat),
    .avs_waitrequest(wait_s), .line0_sub_input(p0), .port_a_pin(pa), .port_b_pin(pb),
    .port_c_pin(pc), .standby(stby), .line_irq(lirq), .irq(irq), .wake_req(wake));

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    adr <= a;
    wdat <= d;
    wr_s <= w;
    rd_s <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (wait_s !== 1'b0);
    q = rdat;
    chk(32'(n), 32'h2);
    wr_s <= 1'b0;
    rd_s <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk(q, e);
  endtask

  task automatic ck_irq(input logic [4:0] e);
    chk(32'({irq, lirq}), 32'(e));
  endtask

  task automatic results();
    if (bad_count == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #500000;
    bad_count++;
    results();
  end

  initial begin
    tick(6);
    reset_n <= 1'b1;
    tick(4);
    ck_irq(5'h0);
    rd(EEI_OFS_EN, 32'h0);
    rd(EEI_OFS_RISE, 32'h0);
    rd(EEI_OFS_FALL, 32'h0007FFFF);
    rd(EEI_OFS_FLAG, 32'h0);
    rd(EEI_OFS_SEL, 32'h0);
    rd(5'h14, 32'h0);
    wr(EEI_OFS_EN, 32'hFFFFFFFF);
    rd(EEI_OFS_EN, 32'h0007FFFF);
    wr(EEI_OFS_EN, 32'h0);
    wr(EEI_OFS_RISE, 32'hFFFFFFFF);
    rd(EEI_OFS_RISE, 32'h0007FFFF);
    wr(EEI_OFS_RISE, 32'h0);
    be <= 4'h1;
    wr(EEI_OFS_SEL, 32'hFFFFFFFF);
    be <= 4'hF;
    rd(EEI_OFS_SEL, 32'h000000FF);
    wr(EEI_OFS_SEL, 32'h0);
    for (int i = 0; i < 16; i++) begin
      wr(EEI_OFS_EN, 32'h1 << ((i + 1) % 16));
      l0[i] <= 1'b0;
      tick(6);
      rd(EEI_OFS_FLAG, 32'h1 << i);
      ck_irq(5'h0);
      wr(EEI_OFS_EN, 32'h1 << i);
      tick(2);
      ck_irq(5'h11);
      wr(EEI_OFS_FLAG, 32'h0);
      rd(EEI_OFS_FLAG, 32'h1 << i);
      wr(EEI_OFS_FLAG, 32'h1 << i);
      l0[i] <= 1'b1;
      tick(6);
      rd(EEI_OFS_FLAG, 32'h0);
      ck_irq(5'h0);
    end
    wr(EEI_OFS_EN, 32'h0);
    wr(EEI_OFS_FALL, 32'h0);
    wr(EEI_OFS_RISE, 32'h00010000);
    for (int k = 0; k < 16; k++) begin
      wr(EEI_OFS_SEL, 32'(k));
      la <= ~(16'h1 << k);
      tick(6);
      rd(EEI_OFS_FLAG, 32'h0);
      la <= 16'hFFFF;
      tick(6);
      rd(EEI_OFS_FLAG, 32'h00010000);
      wr(EEI_OFS_FLAG, 32'hFFFFFFFF);
      la <= 16'h0;
      tick(6);
      rd(EEI_OFS_FLAG, 32'h0);
    end
    wr(EEI_OFS_SEL, 32'h0);
    wr(EEI_OFS_RISE, 32'h00020000);
    wr(EEI_OFS_FALL, 32'h00020000);
    lb <= 16'hFFFF;
    tick(6);
    lb <= 16'h0;
    tick(6);
    rd(EEI_OFS_FLAG, 32'h0);
    wr(EEI_OFS_SEL, 32'h000000F0);
    lb <= 16'h8000;
    tick(6);
    rd(EEI_OFS_FLAG, 32'h00020000);
    wr(EEI_OFS_FLAG, 32'h00020000);
    lb <= 16'h0;
    tick(6);
    rd(EEI_OFS_FLAG, 32'h00020000);
    wr(EEI_OFS_EN, 32'h00020000);
    tick(2);
    ck_irq(5'h14);
    wr(EEI_OFS_FLAG, 32'h00020000);
    tick(2);
    ck_irq(5'h0);
    wr(EEI_OFS_EN, 32'h0);
    wr(EEI_OFS_RISE, 32'h0);
    wr(EEI_OFS_FALL, 32'h00040000);
    wr(EEI_OFS_SEL, 32'h00000B00);
    lc <= 12'h800;
    tick(6);
    rd(EEI_OFS_FLAG, 32'h0);
    lc <= 12'h0;
    tick(6);
    rd(EEI_OFS_FLAG, 32'h00040000);
    wr(EEI_OFS_EN, 32'h00040000);
    tick(2);
    ck_irq(5'h18);
    wr(EEI_OFS_FLAG, 32'h00040000);
    wr(EEI_OFS_EN, 32'h0);
    wr(EEI_OFS_SEL, 32'h00000C00);
    lc <= 12'hFFF;
    tick(6);
    lc <= 12'h0;
    tick(6);
    rd(EEI_OFS_FLAG, 32'h0);
    wr(EEI_OFS_SEL, 32'h00000003);
    wr(EEI_OFS_FALL, 32'h0);
    wr(EEI_OFS_RISE, 32'h00010000);
    wr(EEI_OFS_EN, 32'h00010000);
    stby <= 1'b1;
    tick(3);
    chk(32'(wake), 32'h0);
    la <= 16'h0008;
    tick(6);
    chk(32'(wake), 32'h1);
    ck_irq(5'h12);
    wr(EEI_OFS_EN, 32'h0);
    wr(EEI_OFS_FALL, 32'h00010000);
    wr(EEI_OFS_EN, 32'h00010000);
    tick(3);
    chk(32'(wake), 32'h0);
    la <= 16'h0;
    tick(6);
    chk(32'(wake), 32'h1);
    stby <= 1'b0;
    tick(3);
    chk(32'(wake), 32'h0);
    results();
  end
endmodule // eei_top_tb_top
